// [rtl/ppc_host.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Compat low in bus modes: freq selects low.
// - Compat low bus mode: shared ref pins low.
// - Serial bit taken per rising clock, enable low.
// - Serial load is twenty bits, ref5 first.
// - Compat low: first four serial bits zero.
// - Serial order ref5..4, main8..7, pre, main, ref, swallow.
module ppc_host (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  output logic             parallel_select_n_o,
  output logic             serial_select_o,
  output logic             compat_mode_n_o,
  output logic             bus_freq_select_o,
  output logic             serial_freq_select_o,
  output ppc_pkg::ppc_word_t program_port_o,
  output ppc_pkg::ppc_pins_t pins_o
);

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;
  logic [3:0]  ctrl_reg;
  ppc_pkg::ppc_word_t word_reg;
  logic        busy_reg;
  logic [15:0] done_reg;

  ppc_axil_slave u_slave (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .awaddr_i  (s_awaddr_i),
    .awvalid_i (s_awvalid_i),
    .awready_o (s_awready_o),
    .wdata_i   (s_wdata_i),
    .wstrb_i   (s_wstrb_i),
    .wvalid_i  (s_wvalid_i),
    .wready_o  (s_wready_o),
    .bresp_o   (s_bresp_o),
    .bvalid_o  (s_bvalid_o),
    .bready_i  (s_bready_i),
    .araddr_i  (s_araddr_i),
    .arvalid_i (s_arvalid_i),
    .arready_o (s_arready_o),
    .rdata_o   (s_rdata_o),
    .rresp_o   (s_rresp_o),
    .rvalid_o  (s_rvalid_o),
    .rready_i  (s_rready_i),
    .wr_en_o   (wr_en),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_ok_i   (rd_ok),
    .wr_ok_i   (wr_ok)
  );

  // Writes to control, word and command answer OKAY; during a load they are dropped so pins never shift mid-load
  assign wr_ok = (wr_addr == ppc_pkg::CTRL_OFF) || (wr_addr == ppc_pkg::WORD_OFF)
              || (wr_addr == ppc_pkg::CMD_OFF);
  logic start;
  assign start = wr_en && (wr_addr == ppc_pkg::CMD_OFF) && wr_strb[0] && !busy_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= ppc_pkg::CTRL_RST;
      word_reg <= ppc_pkg::WORD_RST;
    end else if (wr_en && !busy_reg) begin
      if (wr_addr == ppc_pkg::CTRL_OFF && wr_strb[0]) begin
        ctrl_reg <= wr_data[3:0];
      end
      if (wr_addr == ppc_pkg::WORD_OFF) begin
        if (wr_strb[0]) word_reg[7:0]   <= wr_data[7:0];
        if (wr_strb[1]) word_reg[15:8]  <= wr_data[15:8];
        if (wr_strb[2]) word_reg[19:16] <= wr_data[19:16];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h00000000;
    unique case (rd_addr)
      ppc_pkg::CTRL_OFF:   rd_data = {28'h0000000, ctrl_reg};
      ppc_pkg::WORD_OFF:   rd_data = {12'h000, word_reg};
      ppc_pkg::CMD_OFF:    rd_data = 32'h00000000;
      ppc_pkg::STATUS_OFF: rd_data = {done_reg, 15'h0000, busy_reg};
      default:             rd_ok   = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Mode and frequency select pins
  // --------------------------------------------------------------------------
  logic par_mode;
  logic ser_mode;
  logic compat_low;
  assign par_mode   = ctrl_reg[ppc_pkg::CTRL_PAR_POS];
  assign ser_mode   = ctrl_reg[ppc_pkg::CTRL_SER_POS];
  assign compat_low = !ctrl_reg[ppc_pkg::CTRL_COMPAT_POS];
  assign parallel_select_n_o = par_mode;
  assign serial_select_o     = ser_mode;
  assign compat_mode_n_o     = !compat_low;
  // Freq selects held low in compat mode so primaries stay inactive
  assign bus_freq_select_o    = !par_mode && !ser_mode && !compat_low
                                && ctrl_reg[ppc_pkg::CTRL_FSEL_POS];
  assign serial_freq_select_o = !par_mode && ser_mode && !compat_low
                                && ctrl_reg[ppc_pkg::CTRL_FSEL_POS];

  // Parallel pins carry the word; extended bits have no pins, so they stay zero
  always_comb begin
    program_port_o = '0;
    if (par_mode) begin
      program_port_o = word_reg;
      program_port_o.main_cnt[8:7] = 2'h0;
      program_port_o.ref_cnt[5:4]  = 2'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Load sequencer
  // --------------------------------------------------------------------------
  typedef enum { ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_HOP, ST_END } ppc_state_t;
  ppc_state_t  state_reg;
  logic [3:0]  tick_reg;
  logic [4:0]  idx_reg;
  logic [19:0] ser_vec;
  logic [7:0]  byte_sel;
  ppc_pkg::ppc_word_t eff;

  // Extended bits sent as zero in compat mode
  always_comb begin
    eff = word_reg;
    if (compat_low) begin
      eff.main_cnt[8:7] = 2'h0;
      eff.ref_cnt[5:4]  = 2'h0;
    end
  end
  assign ser_vec = {eff.ref_cnt[5:4], eff.main_cnt[8:7], eff.pre_en_n,
                    eff.main_cnt[6:0], eff.ref_cnt[3:0], eff.swallow_cnt};

  // Byte per strobe index 0 swallow, 1 main low, 2 main high
  always_comb begin
    unique case (idx_reg)
      5'd0:    byte_sel = {eff.ref_cnt[3:0], eff.swallow_cnt};
      5'd1:    byte_sel = {eff.pre_en_n, eff.main_cnt[6:0]};
      default: byte_sel = {4'h0, eff.ref_cnt[5:4], eff.main_cnt[8:7]};
    endcase
  end

  // Half-period timer sets the strobe and serial clock rate
  logic tick;
  assign tick = (tick_reg == 4'(ppc_pkg::HALF_CYC - 1));
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_reg <= 4'h0;
    end else if (state_reg == ST_IDLE || tick) begin
      tick_reg <= 4'h0;
    end else begin
      tick_reg <= tick_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      idx_reg   <= 5'd0;
      busy_reg  <= 1'b0;
      done_reg  <= 16'h0000;
      pins_o    <= 15'h0001;  // Enable idles high, so no false transfer edge after reset
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          pins_o.shift_enable_n <= 1'b1;
          if (start) begin
            busy_reg  <= 1'b1;
            idx_reg   <= 5'd0;
            state_reg <= par_mode ? ST_END : ST_SETUP;
          end
        end
        // Present data a half period before the rising edge
        ST_SETUP: if (tick) begin
          if (ser_mode) begin
            pins_o.shift_enable_n <= 1'b0;
            pins_o.serial_in      <= ser_vec[5'd19 - idx_reg];
          end else begin
            pins_o.host_data_bus <= byte_sel;
          end
          state_reg <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          if (ser_mode) pins_o.serial_clk <= 1'b1;
          else begin
            pins_o.swallow_write_strobe   <= (idx_reg == 5'd0);
            pins_o.main_low_write_strobe  <= (idx_reg == 5'd1);
            pins_o.main_high_write_strobe <= (idx_reg == 5'd2);
          end
          state_reg <= ST_LOW;
        end
        ST_LOW: if (tick) begin
          pins_o.serial_clk             <= 1'b0;
          pins_o.swallow_write_strobe   <= 1'b0;
          pins_o.main_low_write_strobe  <= 1'b0;
          pins_o.main_high_write_strobe <= 1'b0;
          idx_reg <= idx_reg + 5'd1;
          if (idx_reg == (ser_mode ? 5'(ppc_pkg::SER_BITS - 1) : 5'd2)) begin
            state_reg <= ST_HOP;
          end else begin
            state_reg <= ST_SETUP;
          end
        end
        // Serial: enable rise transfers; bus: hop write pulse transfers
        ST_HOP: if (tick) begin
          if (ser_mode) begin
            pins_o.shift_enable_n <= 1'b1;
            state_reg <= ST_END;
          end else if (!pins_o.hop_write) begin
            pins_o.hop_write <= 1'b1;
          end else begin
            pins_o.hop_write <= 1'b0;
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          pins_o.hop_write <= 1'b0;
          busy_reg  <= 1'b0;
          done_reg  <= done_reg + 16'h0001;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// [rtl/ppc_pkg.sv]
package ppc_pkg;

  // --------------------------------------------------------------------------
  // Software register map (AXI4-Lite byte offsets)
  // --------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;  // Mode, compat, freq select
  localparam logic [7:0] WORD_OFF   = 8'h04;  // Program word to load
  localparam logic [7:0] CMD_OFF    = 8'h08;  // Write starts a load
  localparam logic [7:0] STATUS_OFF = 8'h0C;  // Busy and loads done

  // --------------------------------------------------------------------------
  // Control field positions and reset values
  // --------------------------------------------------------------------------
  localparam int CTRL_PAR_POS    = 0;
  localparam int CTRL_SER_POS    = 1;
  localparam int CTRL_COMPAT_POS = 2;
  localparam int CTRL_FSEL_POS   = 3;
  localparam int CMD_HOP_POS     = 0;
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [19:0] WORD_RST = 20'h00000;

  // --------------------------------------------------------------------------
  // Program word layout and timing
  // --------------------------------------------------------------------------
  localparam int SER_BITS      = 20;
  localparam int LINK_NS       = 125;
  localparam int CLK_NS        = 10;
  localparam int HALF_CYC      = (LINK_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       pre_en_n;
    logic [5:0] ref_cnt;
    logic [8:0] main_cnt;
    logic [3:0] swallow_cnt;
  } ppc_word_t;

  typedef struct packed {
    logic [7:0] host_data_bus;
    logic       swallow_write_strobe;
    logic       main_low_write_strobe;
    logic       main_high_write_strobe;
    logic       hop_write;
    logic       serial_in;
    logic       serial_clk;
    logic       shift_enable_n;
  } ppc_pins_t;

  typedef enum logic [1:0] { ACC_IDLE, ACC_SLV, ACC_OK } ppc_dummy_t;

endpackage

// [rtl/ppc_axil_slave.sv]
`timescale 1ns/1ps
module ppc_axil_slave (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic             wr_en_o,
  output logic [7:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [3:0]       wr_strb_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_ok_i,
  input  wire logic        wr_ok_i
);

  // --------------------------------------------------------------------------
  // Write channel: take address and data in either order, then respond
  // --------------------------------------------------------------------------
  logic       aw_have_reg;
  logic       w_have_reg;
  logic [7:0] aw_reg;
  logic [31:0] w_reg;
  logic [3:0] s_reg;

  assign awready_o = !aw_have_reg && !bvalid_o;
  assign wready_o  = !w_have_reg && !bvalid_o;
  assign wr_en_o   = aw_have_reg && w_have_reg && !bvalid_o;
  assign wr_addr_o = aw_reg;
  assign wr_data_o = w_reg;
  assign wr_strb_o = s_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= 8'h00;
      w_reg       <= 32'h00000000;
      s_reg       <= 4'h0;
      bvalid_o    <= 1'b0;
      bresp_o     <= 2'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_have_reg <= 1'b1;
        aw_reg      <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_have_reg <= 1'b1;
        w_reg      <= wdata_i;
        s_reg      <= wstrb_i;
      end
      if (wr_en_o) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_o    <= 1'b1;
        bresp_o     <= wr_ok_i ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel: one cycle after the address the data stand registered
  // --------------------------------------------------------------------------
  assign arready_o = !rvalid_o;
  assign rd_addr_o = araddr_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h00000000;
      rresp_o  <= 2'h0;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_data_i;
      rresp_o  <= rd_ok_i ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

endmodule

// [sim/ppc_host_checker.sv]
`timescale 1ns/1ps
module ppc_host_checker (
  input wire logic               clk_i,
  input wire logic               arst_n_i,
  input wire logic               s_bvalid_o,
  input wire logic               s_bready_i,
  input wire logic               parallel_select_n_o,
  input wire logic               serial_select_o,
  input wire logic               compat_mode_n_o,
  input wire logic               bus_freq_select_o,
  input wire logic               serial_freq_select_o,
  input wire ppc_pkg::ppc_word_t program_port_o,
  input wire ppc_pkg::ppc_pins_t pins_o
);
  logic [4:0] bit_cnt;
  logic       ser_m;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  assign ser_m = serial_select_o && !parallel_select_n_o;

  // Rises of the serial clock in a frame; idle enable clears the count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt <= 5'h00;
    end else if (pins_o.shift_enable_n) begin
      bit_cnt <= 5'h00;
    end else if ($rose(pins_o.serial_clk)) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  sequence s_frame_end;
    $rose(pins_o.shift_enable_n) && ser_m;
  endsequence
  sequence s_early_bit;
    $rose(pins_o.serial_clk) && ser_m && !compat_mode_n_o && bit_cnt < 5'h04;
  endsequence

  chk_fsel_compat: assert property (!compat_mode_n_o |-> !bus_freq_select_o && !serial_freq_select_o)
    else $error("freq select high with compat low");
  chk_shared_pins: assert property (!parallel_select_n_o && !serial_select_o && !compat_mode_n_o
    |-> program_port_o.ref_cnt[3:2] == 2'h0)
    else $error("shared ref pins not low in bus mode");
  chk_clk_enable: assert property ($rose(pins_o.serial_clk) |-> !pins_o.shift_enable_n)
    else $error("serial clock rose with enable high");
  chk_data_setup: assert property ($rose(pins_o.serial_clk) |-> $stable(pins_o.serial_in))
    else $error("serial data changed at clock rise");
  chk_clk_idle: assert property (pins_o.shift_enable_n[*2] |-> !pins_o.serial_clk)
    else $error("serial clock high outside frame");
  chk_frame_bits: assert property (s_frame_end |-> bit_cnt == 5'h14)
    else $error("serial frame not twenty bits");
  chk_lead_zero: assert property (s_early_bit |-> !pins_o.serial_in)
    else $error("leading serial bit not zero");
  chk_par_ext: assert property (parallel_select_n_o
    |-> program_port_o.main_cnt[8:7] == 2'h0 && program_port_o.ref_cnt[5:4] == 2'h0)
    else $error("extended bits driven in parallel mode");
  chk_strobe_hold: assert property ($fell(pins_o.swallow_write_strobe | pins_o.main_low_write_strobe
    | pins_o.main_high_write_strobe) |-> $stable(pins_o.host_data_bus))
    else $error("bus data changed during strobe");
  chk_bresp_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o)
    else $error("write response dropped early");
endmodule

// [sim/ppc_dev_model.sv]
`timescale 1ns/1ps
module ppc_dev_model (
  input wire logic               parallel_select_n_i,
  input wire logic               serial_select_i,
  input wire logic               compat_mode_n_i,
  input wire logic               bus_freq_select_i,
  input wire logic               serial_freq_select_i,
  input wire ppc_pkg::ppc_word_t program_port_i,
  input wire ppc_pkg::ppc_pins_t pins_i,
  output ppc_pkg::ppc_word_t     counters_o
);
  ppc_pkg::ppc_word_t prim;
  ppc_pkg::ppc_word_t sec;
  ppc_pkg::ppc_word_t pw;
  logic [19:0]        shreg;
  logic [7:0]         dbus;
  logic               bus_m;
  logic               ser_m;

  // Power-on clear so outputs are defined before any load
  initial begin
    prim = '0;
    sec = '0;
    shreg = '0;
  end

  assign bus_m = !parallel_select_n_i && !serial_select_i;
  assign ser_m = !parallel_select_n_i && serial_select_i;
  // Shared pads are ORed, so a stray ref pin corrupts the low bus bits
  assign dbus = pins_i.host_data_bus | {6'h00, program_port_i.ref_cnt[3:2]};
  // Serial shift order ref5 first, swallow0 last
  assign pw = ser_m ? {shreg[15], shreg[19:18], shreg[7:4], shreg[17:16], shreg[14:8],
                       shreg[3:0]} : prim;

  // Primary byte latches on strobe rises
  always @(posedge pins_i.swallow_write_strobe) if (bus_m) begin
    {prim.ref_cnt[3:0], prim.swallow_cnt} = dbus;
  end
  always @(posedge pins_i.main_low_write_strobe) if (bus_m) begin
    {prim.pre_en_n, prim.main_cnt[6:0]} = dbus;
  end
  always @(posedge pins_i.main_high_write_strobe) if (bus_m) begin
    {prim.ref_cnt[5:4], prim.main_cnt[8:7]} = dbus[3:0];
  end
  // Serial shift while enable is low
  always @(posedge pins_i.serial_clk) if (ser_m && !pins_i.shift_enable_n) begin
    shreg = {shreg[18:0], pins_i.serial_in};
  end
  // Secondary transfer on hop or enable rise
  always @(posedge pins_i.hop_write) if (bus_m || ser_m) begin
    sec = pw;
  end
  always @(posedge pins_i.shift_enable_n) if (ser_m) begin
    sec = pw;
  end

  // Output mux; extended bits forced low when unreachable
  always_comb begin
    if (!parallel_select_n_i) begin
      counters_o = (bus_m ? bus_freq_select_i : serial_freq_select_i) ? pw : sec;
    end else begin
      counters_o = program_port_i;
    end
    if (!compat_mode_n_i || parallel_select_n_i) begin
      counters_o.main_cnt[8:7] = 2'h0;
      counters_o.ref_cnt[5:4] = 2'h0;
    end
  end
endmodule

// [sim/ppc_host_tb.sv]
`timescale 1ns/1ps
module ppc_host_tb;
  logic clk_i, arst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0]  rr;
  logic [1:0]  s_bresp_o, s_rresp_o;
  logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [31:0] s_rdata_o;
  logic        par_n, ser, cmp_n, bfs, sfs;
  ppc_pkg::ppc_word_t pp, cnt;
  ppc_pkg::ppc_pins_t pins;
  int n_errors, comparisons, cyc;
  logic [3:0]  cs [7] = '{4'h4, 4'h6, 4'h2, 4'h0, 4'h5, 4'hC, 4'hE};
  logic [19:0] ws [7] = '{20'hA5C3B, 20'hF35A9, 20'hFFFFF, 20'h6BCDE, 20'hFFFFF, 20'h3C96E,
                          20'h5A5A5};

  ppc_host uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
    .s_awready_o(s_awready_o), .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid),
    .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(s_arready_o),
    .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o), .s_rvalid_o(s_rvalid_o), .s_rready_i(rready),
    .parallel_select_n_o(par_n), .serial_select_o(ser), .compat_mode_n_o(cmp_n),
    .bus_freq_select_o(bfs), .serial_freq_select_o(sfs), .program_port_o(pp), .pins_o(pins));
  ppc_dev_model dev (.parallel_select_n_i(par_n), .serial_select_i(ser),
    .compat_mode_n_i(cmp_n), .bus_freq_select_i(bfs), .serial_freq_select_i(sfs),
    .program_port_i(pp), .pins_i(pins), .counters_o(cnt));

  // 100 MHz clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (awvalid && s_awready_o) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && s_wready_o) begin dd = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge clk_i); while (s_bvalid_o !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, s_bresp_o}, {30'h0, er});
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk_i); while (s_arready_o !== 1'b1);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(posedge clk_i); while (s_rvalid_o !== 1'b1);
    d = s_rdata_o; r = s_rresp_o; rready <= 1'b0;
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axr(a, rd, rr);
    check("rdata", rd, e);
    check("rresp", {30'h0, rr}, {30'h0, er});
  endtask

  // One full load; the extended bits only survive in bus and serial modes with compat high
  task automatic ld(input logic [3:0] c, input logic [19:0] w, input logic [15:0] k);
    ppc_pkg::ppc_word_t e;
    int n;
    e = w;
    if (c[0] || !c[2]) begin e.main_cnt[8:7] = 2'h0; e.ref_cnt[5:4] = 2'h0; end
    axw(ppc_pkg::CTRL_OFF, {28'h0, c}, ppc_pkg::RESP_OKAY);
    axw(ppc_pkg::WORD_OFF, {12'h0, w}, ppc_pkg::RESP_OKAY);
    axw(ppc_pkg::CMD_OFF, 32'h00000001, ppc_pkg::RESP_OKAY);
    // A config write during a bus or serial load is answered but must be dropped
    if (!c[0]) axw(ppc_pkg::CTRL_OFF, {28'h0, ~c}, ppc_pkg::RESP_OKAY);
    n = 0;
    do begin axr(ppc_pkg::STATUS_OFF, rd, rr); n++; end while (rd[0] !== 1'b0 && n < 400);
    // A load still busy after the poll limit counts as a mismatch here
    check("busy", {31'h0, rd[0]}, 32'h0);
    check("done_count", {16'h0, rd[31:16]}, {16'h0, k});
    check("counters", {12'h0, cnt}, {12'h0, e});
    check("fsel", {30'h0, bfs, sfs}, {30'h0, c[3] & c[2] & !c[0] & !c[1],
                                      c[3] & c[2] & !c[0] & c[1]});
    chkrd(ppc_pkg::CTRL_OFF, {28'h0, c}, ppc_pkg::RESP_OKAY);
    chkrd(ppc_pkg::WORD_OFF, {12'h0, w}, ppc_pkg::RESP_OKAY);
  endtask

  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0; arst_n_i = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    n_errors = 0; comparisons = 0; cyc = 0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chkrd(ppc_pkg::CTRL_OFF, 32'h0, ppc_pkg::RESP_OKAY);
    check("reset_counters", {12'h0, cnt}, 32'h0);
    chkrd(8'h10, 32'h0, ppc_pkg::RESP_SLVERR);
    axw(8'h10, 32'h1, ppc_pkg::RESP_SLVERR);
    chkrd(ppc_pkg::CMD_OFF, 32'h0, ppc_pkg::RESP_OKAY);
    for (int i = 0; i < 7; i++) ld(cs[i], ws[i], 16'(i + 1));
    // Primary still holds the last bus word, secondary the last serial word
    axw(ppc_pkg::CTRL_OFF, 32'h0000000C, ppc_pkg::RESP_OKAY);
    check("ping_primary", {12'h0, cnt}, {12'h0, ws[5]});
    axw(ppc_pkg::CTRL_OFF, 32'h00000004, ppc_pkg::RESP_OKAY);
    check("ping_secondary", {12'h0, cnt}, {12'h0, ws[6]});
    summarize();
  end
endmodule

bind ppc_host ppc_host_checker chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_bvalid_o(s_bvalid_o),
  .s_bready_i(s_bready_i), .parallel_select_n_o(parallel_select_n_o),
  .serial_select_o(serial_select_o), .compat_mode_n_o(compat_mode_n_o),
  .bus_freq_select_o(bus_freq_select_o), .serial_freq_select_o(serial_freq_select_o),
  .program_port_o(program_port_o), .pins_o(pins_o));
